// ---- hw/dac_link_pkg.sv ----
// Shared constants and types for the serial DAC control block
`default_nettype none
package dac_link_pkg;
    localparam int         CODE_W        = 10;
    localparam logic [6:0] DEV_ADDR      = 7'h48;
    localparam logic [7:0] CMD_CODE      = 8'h00;
    localparam logic [7:0] CMD_SETTINGS  = 8'h01;
    localparam logic [9:0] CODE_POR      = 10'h000;
    localparam logic       STANDBY_POR   = 1'h0;
    localparam logic       RW_READ       = 1'h1;
    localparam logic       MEM_CODE      = 1'h0;
    localparam logic       MEM_SET       = 1'h1;
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam logic [3:0] ACK_DONE      = 4'h9;
    localparam logic [1:0] IDX_FIRST     = 2'h0;
    localparam logic [1:0] IDX_SECOND    = 2'h1;
    localparam logic [1:0] IDX_DONE      = 2'h2;
    localparam int         STANDBY_POS   = 0;
    localparam int         CODE_HI_LSB   = 2;
    localparam int         LO_MSB        = 7;
    localparam int         LO_LSB        = 6;
    localparam logic [5:0] LO_PAD        = 6'h00;
    localparam logic [6:0] SET_PAD       = 7'h00;
    localparam logic [8:0] SET_WORD_PAD  = 9'h000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_SKIP  = 3'b101
    } link_state_t;
endpackage : dac_link_pkg
`default_nettype wire

// ---- hw/dac_serial_ctrl.sv ----
// Two-wire target port holding the converter code and standby request
`default_nettype none
// Summary of operation
// RULE_01 - Target only; never drives clock or starts
// RULE_02 - Answers only fixed address 1001000b
// RULE_03 - Standby bit one enters standby, zero normal
// RULE_04 - Standby halts conversion activity
// RULE_05 - Serial port keeps working during standby
// RULE_06 - Stored code drives converter, output code/1024
// RULE_07 - Converter code is ten bits wide
// RULE_08 - Reset sets all registers and mode
// RULE_09 - Bits shift only on master serial clock
// RULE_10 - Data line shared; device drives ack, read
// RULE_11 - Address, command, then data into selected register
// RULE_12 - Command 00h code, 01h settings register
// RULE_13 - Eighth address bit: one read, zero write
// RULE_14 - Acknowledge address only on match, else release
// RULE_15 - Code kept through standby, resumes after clear
module dac_serial_ctrl
    import dac_link_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              scl,
    input  wire logic              sda_in,
    output logic                   sda_out_ff,
    output logic                   sda_oe_ff,
    output logic      [CODE_W-1:0] dac_code_ff,
    output logic                   dac_run_ff,
    output logic                   standby_request_bit_ff
);
    // Link clock domain: sample data on each rising serial clock
    logic              rx_bit_ff;
    logic              nxt_rx_bit;
    logic              bit_tgl_ff;
    logic              nxt_bit_tgl;

    // Local clock domain: synchronisers and edge history
    logic              sda_s1_ff;
    logic              sda_s2_ff;
    logic              sda_prev_ff;
    logic              scl_s1_ff;
    logic              scl_s2_ff;
    logic              scl_prev_ff;
    logic              tgl_s1_ff;
    logic              tgl_s2_ff;
    logic              tgl_s3_ff;

    // Protocol state
    link_state_t       state_ff;
    link_state_t       nxt_state;
    logic [3:0]        bit_cnt_ff;
    logic [3:0]        nxt_bit_cnt;
    logic [7:0]        shift_ff;
    logic [7:0]        nxt_shift;
    logic [7:0]        cmd_ff;
    logic [7:0]        nxt_cmd;
    logic [7:0]        hi_ff;
    logic [7:0]        nxt_hi;
    logic [1:0]        idx_ff;
    logic [1:0]        nxt_idx;
    logic [7:0]        tx_ff;
    logic [7:0]        nxt_tx;
    logic              ack_req_ff;
    logic              nxt_ack_req;
    logic              nxt_sda_oe;
    logic              nxt_sda_out;
    logic [CODE_W-1:0] nxt_dac_code;
    logic              nxt_standby;
    logic              nxt_run;

    logic              start_ev;
    logic              stop_ev;
    logic              rise_ev;
    logic              fall_ev;
    logic [7:0]        new_byte;
    logic              wr_en;
    logic              wr_addr;
    logic [CODE_W-1:0] wr_data;
    logic [CODE_W-1:0] rd_data;

    // Byte returned on a read for the selected register and byte index
    function automatic logic [7:0] read_byte(
        input logic              sel,
        input logic [1:0]        idx,
        input logic [CODE_W-1:0] word
    );
        logic [7:0] res;
        res = {SET_PAD, word[STANDBY_POS]};
        if (sel == MEM_CODE) begin
            if (idx == IDX_FIRST) begin
                res = word[CODE_W-1:CODE_HI_LSB];
            end else begin
                res = {word[CODE_HI_LSB-1:0], LO_PAD};
            end
        end
        return res;
    endfunction : read_byte

    // Sample the data line on the master's clock only
    always_comb begin
        nxt_rx_bit  = sda_in;
        nxt_bit_tgl = ~bit_tgl_ff;
    end

    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            rx_bit_ff  <= 1'h0;
            bit_tgl_ff <= 1'h0;
        end else begin
            rx_bit_ff  <= nxt_rx_bit; // RULE_09
            bit_tgl_ff <= nxt_bit_tgl;
        end
    end

    // Two-stage synchronisers for both pins and the bit toggle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_s1_ff   <= 1'h1;
            sda_s2_ff   <= 1'h1;
            sda_prev_ff <= 1'h1;
            scl_s1_ff   <= 1'h1;
            scl_s2_ff   <= 1'h1;
            scl_prev_ff <= 1'h1;
            tgl_s1_ff   <= 1'h0;
            tgl_s2_ff   <= 1'h0;
            tgl_s3_ff   <= 1'h0;
        end else begin
            sda_s1_ff   <= sda_in;
            sda_s2_ff   <= sda_s1_ff;
            sda_prev_ff <= sda_s2_ff;
            scl_s1_ff   <= scl;
            scl_s2_ff   <= scl_s1_ff;
            scl_prev_ff <= scl_s2_ff;
            tgl_s1_ff   <= bit_tgl_ff;
            tgl_s2_ff   <= tgl_s1_ff;
            tgl_s3_ff   <= tgl_s2_ff;
        end
    end

    // Bus conditions seen from the master's lines
    always_comb begin
        start_ev = scl_s2_ff && scl_prev_ff && sda_prev_ff && !sda_s2_ff;
        stop_ev  = scl_s2_ff && scl_prev_ff && !sda_prev_ff && sda_s2_ff;
        rise_ev  = tgl_s2_ff ^ tgl_s3_ff;
        fall_ev  = scl_prev_ff && !scl_s2_ff;
        new_byte = {shift_ff[6:0], rx_bit_ff};
    end

    reg_store u_store (
        .clk        (clk),
        .reset      (reset),
        .wr_en      (wr_en),
        .wr_addr    (wr_addr),
        .wr_data    (wr_data),
        .rd_addr    (cmd_ff[0]),
        .rd_data_ff (rd_data)
    );

    always_comb begin
        nxt_state    = state_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_cmd      = cmd_ff;
        nxt_hi       = hi_ff;
        nxt_idx      = idx_ff;
        nxt_tx       = tx_ff;
        nxt_ack_req  = ack_req_ff;
        nxt_sda_oe   = sda_oe_ff;
        nxt_sda_out  = 1'h0; // RULE_01
        nxt_dac_code = dac_code_ff;
        nxt_standby  = standby_request_bit_ff;
        wr_en        = 1'h0;
        wr_addr      = MEM_CODE;
        wr_data      = CODE_POR;
        if (stop_ev) begin
            nxt_state   = ST_IDLE;
            nxt_bit_cnt = BIT_CNT_ZERO;
            nxt_ack_req = 1'h0;
            nxt_sda_oe  = 1'h0;
        end else if (start_ev) begin
            nxt_state   = ST_ADDR;
            nxt_bit_cnt = BIT_CNT_ZERO;
            nxt_ack_req = 1'h0;
            nxt_sda_oe  = 1'h0;
        end else if (rise_ev && (state_ff != ST_IDLE) && (state_ff != ST_SKIP)) begin
            if (bit_cnt_ff < ACK_SLOT) begin
                nxt_shift   = new_byte;
                nxt_tx      = {tx_ff[6:0], 1'h0};
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end else if (bit_cnt_ff == ACK_SLOT) begin
                nxt_bit_cnt = ACK_DONE;
                // Own address ack slot is not the master's answer to a read byte
                if ((state_ff == ST_RDATA) && !ack_req_ff) begin
                    if (rx_bit_ff) begin
                        nxt_state = ST_SKIP;
                    end else begin
                        nxt_idx = idx_ff + 2'h1;
                        nxt_tx  = read_byte(cmd_ff[0], idx_ff + 2'h1, rd_data);
                    end
                end
            end
            if (bit_cnt_ff == BIT_LAST) begin
                case (state_ff)
                    ST_ADDR: begin
                        if (new_byte[7:1] == DEV_ADDR) begin // RULE_02
                            nxt_ack_req = 1'h1; // RULE_14
                            nxt_idx     = IDX_FIRST;
                            if (new_byte[0] == RW_READ) begin // RULE_13
                                nxt_state = ST_RDATA;
                                nxt_tx    = read_byte(cmd_ff[0], IDX_FIRST, rd_data);
                            end else begin
                                nxt_state = ST_CMD;
                            end
                        end else begin
                            nxt_state = ST_SKIP;
                        end
                    end
                    ST_CMD: begin
                        nxt_cmd = new_byte;
                        if ((new_byte == CMD_CODE) || (new_byte == CMD_SETTINGS)) begin // RULE_12
                            nxt_ack_req = 1'h1;
                            nxt_idx     = IDX_FIRST;
                            nxt_state   = ST_WDATA; // RULE_11
                        end else begin
                            nxt_state = ST_SKIP;
                        end
                    end
                    ST_WDATA: begin
                        nxt_ack_req = 1'h1; // RULE_05
                        if (cmd_ff == CMD_CODE) begin
                            if (idx_ff == IDX_FIRST) begin
                                nxt_hi  = new_byte;
                                nxt_idx = IDX_SECOND;
                            end else if (idx_ff == IDX_SECOND) begin
                                wr_en        = 1'h1;
                                wr_addr      = MEM_CODE;
                                wr_data      = {hi_ff, new_byte[LO_MSB:LO_LSB]}; // RULE_07
                                nxt_dac_code = wr_data; // RULE_11
                                nxt_idx      = IDX_DONE;
                            end
                        end else if (idx_ff == IDX_FIRST) begin
                            wr_en       = 1'h1;
                            wr_addr     = MEM_SET;
                            wr_data     = {SET_WORD_PAD, new_byte[STANDBY_POS]};
                            nxt_standby = new_byte[STANDBY_POS]; // RULE_03
                            nxt_idx     = IDX_SECOND;
                        end
                    end
                    ST_RDATA: begin
                        nxt_ack_req = 1'h0;
                    end
                    default: begin
                        nxt_state = ST_SKIP;
                    end
                endcase
            end
        end else if (fall_ev && (state_ff != ST_IDLE) && (state_ff != ST_SKIP)) begin
            if (bit_cnt_ff == ACK_SLOT) begin
                nxt_sda_oe = ack_req_ff; // RULE_10
            end else if (bit_cnt_ff == ACK_DONE) begin
                nxt_bit_cnt = BIT_CNT_ZERO;
                nxt_ack_req = 1'h0;
                nxt_sda_oe  = (state_ff == ST_RDATA) ? !tx_ff[7] : 1'h0;
            end else if ((state_ff == ST_RDATA) && (bit_cnt_ff != BIT_CNT_ZERO)) begin
                nxt_sda_oe = !tx_ff[7]; // RULE_10
            end else begin
                nxt_sda_oe = 1'h0;
            end
        end
        nxt_run = !nxt_standby; // RULE_04
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff               <= ST_IDLE; // RULE_08
            bit_cnt_ff             <= BIT_CNT_ZERO;
            shift_ff               <= 8'h00;
            cmd_ff                 <= CMD_CODE;
            hi_ff                  <= 8'h00;
            idx_ff                 <= IDX_FIRST;
            tx_ff                  <= 8'h00;
            ack_req_ff             <= 1'h0;
            sda_oe_ff              <= 1'h0;
            sda_out_ff             <= 1'h0;
            dac_code_ff            <= CODE_POR;
            standby_request_bit_ff <= STANDBY_POR;
            dac_run_ff             <= !STANDBY_POR;
        end else begin
            state_ff               <= nxt_state;
            bit_cnt_ff             <= nxt_bit_cnt;
            shift_ff               <= nxt_shift;
            cmd_ff                 <= nxt_cmd;
            hi_ff                  <= nxt_hi;
            idx_ff                 <= nxt_idx;
            tx_ff                  <= nxt_tx;
            ack_req_ff             <= nxt_ack_req;
            sda_oe_ff              <= nxt_sda_oe;
            sda_out_ff             <= nxt_sda_out;
            dac_code_ff            <= nxt_dac_code; // RULE_06 RULE_15
            standby_request_bit_ff <= nxt_standby;
            dac_run_ff             <= nxt_run;
        end
    end
endmodule : dac_serial_ctrl
`default_nettype wire

// ---- hw/reg_store.sv ----
// Two-word register store for the converter code and settings, registered read
`default_nettype none
module reg_store
    import dac_link_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              wr_en,
    input  wire logic              wr_addr,
    input  wire logic [CODE_W-1:0] wr_data,
    input  wire logic              rd_addr,
    output logic      [CODE_W-1:0] rd_data_ff
);
    logic [CODE_W-1:0] mem_ff      [2];
    logic [CODE_W-1:0] nxt_mem     [2];
    logic [CODE_W-1:0] nxt_rd_data;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_word
            always_comb begin
                nxt_mem[g] = mem_ff[g];
                if (wr_en && (wr_addr == 1'(g))) begin
                    nxt_mem[g] = wr_data;
                end
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    mem_ff[g] <= CODE_POR;
                end else begin
                    mem_ff[g] <= nxt_mem[g];
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_rd_data = mem_ff[rd_addr];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_ff <= CODE_POR;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end
endmodule : reg_store
`default_nettype wire

// ---- tb/dac_serial_ctrl_bench.sv ----
// Bench for the serial DAC control block driven by a two-wire host model
`default_nettype none
module dac_serial_ctrl_bench
    import dac_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              scl;
    logic              sda_low;
    logic              sda;
    logic              sda_out_ff;
    logic              sda_oe_ff;
    logic              dac_run_ff;
    logic              standby_request_bit_ff;
    logic [CODE_W-1:0] dac_code_ff;
    int                error_cnt = 0;
    int                check_count = 0;

    always #50 clk = ~clk;
    assign sda = ~(sda_oe_ff | sda_low);

    dac_serial_ctrl dac_serial_ctrl_i (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda),
        .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .dac_code_ff(dac_code_ff),
        .dac_run_ff(dac_run_ff), .standby_request_bit_ff(standby_request_bit_ff));
    smbus_host_model smbus_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic st(input logic [9:0] code, input logic stb);
        chk("code", code, dac_code_ff);
        chk("standby", {9'h000, stb}, {9'h000, standby_request_bit_ff});
        chk("run", {9'h000, ~stb}, {9'h000, dac_run_ff});
    endtask : st

    task automatic wb(input logic [7:0] tx, input logic exp_ack, input string nm);
        logic [7:0] rx;
        logic       a;
        smbus_host_model_i.xfer(tx, 1'b1, rx, a);
        chk(nm, {9'h000, exp_ack}, {9'h000, a});
    endtask : wb

    task automatic rb(input logic [7:0] exp, input logic slot);
        logic [7:0] rx;
        logic       a;
        smbus_host_model_i.xfer(8'hff, slot, rx, a);
        chk("read byte", {2'b00, exp}, {2'b00, rx});
    endtask : rb

    task automatic wr(input logic [7:0] cmd, input logic [7:0] b0, input logic [7:0] b1, input int n);
        smbus_host_model_i.start();
        wb({DEV_ADDR, ~RW_READ}, 1'b1, "addr ack");
        wb(cmd, 1'b1, "cmd ack");
        wb(b0, 1'b1, "data ack");
        if (n > 1) begin
            wb(b1, 1'b1, "data ack");
        end
        smbus_host_model_i.stop();
    endtask : wr

    task automatic rd(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1, input int n);
        smbus_host_model_i.start();
        wb({DEV_ADDR, ~RW_READ}, 1'b1, "addr ack");
        wb(cmd, 1'b1, "cmd ack");
        smbus_host_model_i.start();
        wb({DEV_ADDR, RW_READ}, 1'b1, "read addr ack");
        rb(e0, n == 1);
        if (n > 1) begin
            rb(e1, 1'b1);
        end
        smbus_host_model_i.stop();
    endtask : rd

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // Cuts a hung run short
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (5) @(posedge clk);
        st(CODE_POR, STANDBY_POR);
        $display("test reset done");
        wr(CMD_CODE, 8'hff, 8'hff, 2);
        st(10'h3ff, 1'b0);
        wr(CMD_CODE, 8'ha9, 8'h40, 2);
        st(10'h2a5, 1'b0);
        rd(CMD_CODE, 8'ha9, 8'h40, 2);
        $display("test code write and read done");
        for (int i = 0; i < 7; i++) begin
            smbus_host_model_i.start();
            wb({DEV_ADDR ^ (7'h01 << i), 1'b0}, 1'b0, "foreign addr");
            wb(8'h00, 1'b0, "ignored byte");
            smbus_host_model_i.stop();
        end
        smbus_host_model_i.start();
        wb({DEV_ADDR, ~RW_READ}, 1'b1, "addr ack");
        wb(8'h02, 1'b0, "unknown cmd");
        smbus_host_model_i.stop();
        st(10'h2a5, 1'b0);
        $display("test refusals done");
        wr(CMD_SETTINGS, 8'h01, 8'h00, 1);
        st(10'h2a5, 1'b1);
        rd(CMD_SETTINGS, 8'h01, 8'h00, 1);
        wr(CMD_CODE, 8'h55, 8'h40, 2);
        st(10'h155, 1'b1);
        wr(CMD_SETTINGS, 8'hfe, 8'h00, 1);
        st(10'h155, 1'b0);
        rd(CMD_SETTINGS, 8'h00, 8'h00, 1);
        $display("test standby done");
        conclude();
    end
endmodule : dac_serial_ctrl_bench
`default_nettype wire

// ---- tb/dac_serial_ctrl_props.sv ----
// Concurrent checks on the ports of the serial DAC control block
`default_nettype none
module dac_serial_ctrl_props
    import dac_link_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              scl,
    input wire logic              sda_in,
    input wire logic              sda_out_ff,
    input wire logic              sda_oe_ff,
    input wire logic [CODE_W-1:0] dac_code_ff,
    input wire logic              dac_run_ff,
    input wire logic              standby_request_bit_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    logic [7:0] oe_cnt_ff;
    logic [7:0] nxt_oe_cnt;

    // Counts how long the device holds the data wire low
    always_comb begin
        nxt_oe_cnt = sda_oe_ff ? oe_cnt_ff + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            oe_cnt_ff <= 8'h00;
        end else begin
            oe_cnt_ff <= nxt_oe_cnt;
        end
    end

    a_run_not_standby: assert property (dac_run_ff == !standby_request_bit_ff)
        else $error("run flag disagrees with standby bit");
    a_drive_level_low: assert property (sda_out_ff == 1'h0)
        else $error("data wire driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_ff) |-> !scl)
        else $error("data wire changed while serial clock high");
    a_code_on_bit: assert property ($changed(dac_code_ff) |-> scl)
        else $error("code changed outside a taken bit");
    a_standby_on_bit: assert property ($changed(standby_request_bit_ff) |-> scl)
        else $error("standby changed outside a taken bit");
    a_code_kept_standby: assert property ($changed(standby_request_bit_ff) |-> $stable(dac_code_ff))
        else $error("code changed with standby");
    a_oe_hold_bound: assert property (oe_cnt_ff <= 8'hfa)
        else $error("data wire held low too long");
    a_reset_defaults: assert property ($fell(reset) |-> dac_code_ff == CODE_POR && dac_run_ff
        && standby_request_bit_ff == STANDBY_POR && !sda_oe_ff)
        else $error("wrong state after reset");

    c_ack: cover property ($rose(sda_oe_ff));
    c_standby: cover property ($rose(standby_request_bit_ff));
    c_code: cover property ($changed(dac_code_ff));
endmodule : dac_serial_ctrl_props

bind dac_serial_ctrl dac_serial_ctrl_props dac_serial_ctrl_props_i (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .dac_code_ff(dac_code_ff), .dac_run_ff(dac_run_ff),
    .standby_request_bit_ff(standby_request_bit_ff)
);
`default_nettype wire

// ---- tb/smbus_host_model.sv ----
// Two-wire bus master model that clocks frames into the DAC control block
`default_nettype none
module smbus_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 12;

    // Idle bus: clock and data released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Start or repeated start: data falls while clock is high
    task automatic start();
        sda_low <= 1'b0;
        wait_clk(HALF);
        scl <= 1'b1;
        wait_clk(HALF);
        sda_low <= 1'b1;
        wait_clk(HALF);
        scl <= 1'b0;
        wait_clk(2);
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        wait_clk(HALF);
        scl <= 1'b1;
        wait_clk(HALF);
        sda_low <= 1'b0;
        wait_clk(HALF);
    endtask : stop

    // Data changes only while the clock is low
    task automatic put_bit(input logic b, output logic seen);
        sda_low <= ~b;
        wait_clk(HALF);
        scl <= 1'b1;
        wait_clk(HALF / 2);
        seen = sda;
        wait_clk(HALF / 2);
        scl <= 1'b0;
        wait_clk(2);
    endtask : put_bit

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic slot, output logic [7:0] rx, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], seen);
            rx[i] = seen;
        end
        put_bit(slot, seen);
        ack = ~seen;
    endtask : xfer
endmodule : smbus_host_model
`default_nettype wire
